// File: core/rtc_calendar.sv
// calendar clock unit: registers, prescaler with drift trim, bcd calendar, alarm, power control
// assumes one ahb-lite master, hresetn as power-on reset, reference pins asynchronous to hclk
// Operation
// (RULE1) positive trim adds N reference pulses every 15 seconds
// (RULE2) negative trim removes its magnitude in pulses every 15 seconds
// (RULE3) calibration register cleared by power-on reset only
// (RULE4) module enable writable only while write unlock reads 1
// (RULE5) half second flag read-only, cleared by minutes/seconds write
// (RULE6) power control enable turns the power control function on
// (RULE7) stability window clock divided by two when bit set
// (RULE8) sample window clock divided by two when bit set
// (RULE9) source field picks crystal, rc, 50 Hz or 60 Hz mains
// (RULE10) output field routes alarm, seconds, reference or power control out
// (RULE11) power control register cleared by power-on reset only
// (RULE12) minutes/seconds write restarts the prescalers
// (RULE13) alarm enable self-clears after event when count zero, chime off
// (RULE14) chime wraps count from 00h to FFh, else halts at 00h
// (RULE15) interval field selects half second up to yearly alarm period
// (RULE16) software never programs reserved interval codes
// (RULE17) alarm window pointer selects alarm register pair shown
// (RULE18) access to alarm window decrements pointer, stopping at zero
// (RULE19) repeat count decrements on each alarm event
// (RULE20) year holds two bcd digits, upper bits read zero
// (RULE21) month/day fields at documented bits, unused bits zero
// (RULE22) weekday/hours layout; value registers written only when unlocked
// (RULE23) unlock set accepted only right after 55h then AAh keys
// (RULE24) calendar advances each second with bcd carries
// (RULE25) polarity bit selects active level of power control output
module rtc_calendar #(
	parameter int SECONDARY_CRYSTAL_OSC_HZ  = 32768,
	parameter int LOW_POWER_RC_OSC_HZ  = 31250,
	parameter int STAB_WIN = 8,
	parameter int SAMP_WIN = 4
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        secondary_crystal_osc_pin,
	input  wire logic        low_power_rc_osc_pin,
	input  wire logic        mains_pin,
	output logic             clock_out,
	output logic             power_ctl_out,
	output logic             alarm_pulse
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [2:0]  s1, s2, s3;
	logic        ref_lvl, ref_edge, ref_div2;
	logic        acc, wr, is_cal, is_alv, is_ms;
	logic [7:0]  waddr;
	logic [31:0] rmux;
	logic        module_enable, value_write_unlock, out_en, half_second_flag;
	logic [1:0]  tptr;
	logic [7:0]  trim;
	logic [7:0]  pwc;
	logic        alarm_enable, chime;
	logic [3:0]  alarm_interval_select;
	logic [1:0]  alarm_window_pointer;
	logic [7:0]  alarm_repeat_count;
	rtc_pkg::rtc_time_t  tm, alm;
	rtc_pkg::rtc_unlock_t ul;
	rtc_pkg::rtc_pwr_t    pw;
	logic signed [17:0]  presc, full, half;
	logic        tick_sec, tick_half, tick_d, half_d, match, ev;
	logic [7:0]  win;
	logic        win_step;
	logic [8:0]  c_sec, c_min, c_hr, c_day, c_mth, c_yr;
	logic [4:0]  unused_hsize;

	assign unused_hsize = {hsize, htrans[0], haddr[31]};

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [8:0] rtc_bcd_inc(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			rtc_bcd_inc = {1'b1, first};
		else if (v[3:0] == 4'h9)
			rtc_bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			rtc_bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction : rtc_bcd_inc

	function automatic logic [7:0] rtc_last_day(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == 8'h02)
			rtc_last_day = leap ? 8'h29 : 8'h28;
		else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
			rtc_last_day = 8'h30;
		else
			rtc_last_day = 8'h31;
	endfunction : rtc_last_day

	// ----------------------------------------
	// reference pin synchronisers
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					s1[gi] <= 1'b0;
					s2[gi] <= 1'b0;
					s3[gi] <= 1'b0;
				end
				else if (ce)
				begin
					s1[gi] <= gi == 0 ? secondary_crystal_osc_pin : (gi == 1 ? low_power_rc_osc_pin : mains_pin);
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
				end
			end
		end
	endgenerate

	always_comb
	begin
		unique case (pwc[3:2]) // RULE9
			rtc_pkg::REF_SECONDARY_CRYSTAL_OSC: full = 18'(SECONDARY_CRYSTAL_OSC_HZ);
			rtc_pkg::REF_LOW_POWER_RC_OSC: full = 18'(LOW_POWER_RC_OSC_HZ);
			rtc_pkg::REF_M50:  full = 18'sd50;
			default:           full = 18'sd60;
		endcase
		half = full >>> 1;
		ref_lvl = pwc[3:2] == rtc_pkg::REF_SECONDARY_CRYSTAL_OSC ? s2[0] : (pwc[3:2] == rtc_pkg::REF_LOW_POWER_RC_OSC ? s2[1] : s2[2]);
		ref_edge = pwc[3:2] == rtc_pkg::REF_SECONDARY_CRYSTAL_OSC ? s2[0] & ~s3[0] :
			(pwc[3:2] == rtc_pkg::REF_LOW_POWER_RC_OSC ? s2[1] & ~s3[1] : s2[2] & ~s3[2]);
		tick_sec = module_enable & ref_edge & (presc >= full - 18'sd1);
		tick_half = module_enable & ref_edge & (presc == half - 18'sd1);
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	assign acc = hsel & hready & htrans[1];
	assign is_cal = wr & (waddr == rtc_pkg::ADDR_CAL);
	assign is_ms = wr & (waddr == rtc_pkg::ADDR_MINUTE_SECOND_VALUE) & value_write_unlock;
	assign is_alv = (acc & ~hwrite & haddr[7:0] == rtc_pkg::ADDR_ALVAL) | (wr & waddr == rtc_pkg::ADDR_ALVAL);

	always_comb
	begin
		rmux = 32'h0000_0000;
		unique case (haddr[7:0])
			rtc_pkg::ADDR_CAL:    rmux[15:0] = {module_enable, 1'b0, value_write_unlock, 1'b0, half_second_flag,
				out_en, tptr, trim};
			rtc_pkg::ADDR_PWC:    rmux[15:8] = pwc;
			rtc_pkg::ADDR_ALCFG:  rmux[15:0] = {alarm_enable, chime, alarm_interval_select, alarm_window_pointer,
				alarm_repeat_count};
			rtc_pkg::ADDR_ALVAL:  rmux[15:0] = alarm_window_pointer == 2'h0 ? {alm.min, alm.sec} : // RULE17
				(alarm_window_pointer == 2'h1 ? {5'h00, alm.wd, alm.hr} :
				(alarm_window_pointer == 2'h2 ? {alm.mth, alm.day} : 16'h0000));
			rtc_pkg::ADDR_YEAR:   rmux[7:0] = tm.yr; // RULE20
			rtc_pkg::ADDR_MONTH_DAY_VALUE:  rmux[15:0] = {tm.mth, tm.day}; // RULE21
			rtc_pkg::ADDR_WKHR:   rmux[15:0] = {5'h00, tm.wd, tm.hr}; // RULE22
			rtc_pkg::ADDR_MINUTE_SECOND_VALUE: rmux[15:0] = {tm.min, tm.sec};
			default:              rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr <= 1'b0;
			waddr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			wr <= acc & hwrite;
			waddr <= haddr[7:0];
			if (acc & ~hwrite)
				hrdata <= rmux;
		end
	end

	// ----------------------------------------
	// unlock sequence
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ul <= rtc_pkg::UL_IDLE;
		else if (ce && wr)
		begin
			unique case (ul) // RULE23
				rtc_pkg::UL_IDLE:  ul <= (waddr == rtc_pkg::ADDR_KEY && hwdata[7:0] == rtc_pkg::KEY_FIRST) ?
					rtc_pkg::UL_KEY1 : rtc_pkg::UL_IDLE;
				rtc_pkg::UL_KEY1:  ul <= (waddr == rtc_pkg::ADDR_KEY && hwdata[7:0] == rtc_pkg::KEY_SECOND) ?
					rtc_pkg::UL_ARMED : rtc_pkg::UL_IDLE;
				rtc_pkg::UL_ARMED: ul <= rtc_pkg::UL_IDLE;
				default:           ul <= rtc_pkg::UL_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// calibration and power control registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{module_enable, value_write_unlock, out_en, tptr, trim} <= 13'h0000; // RULE3
			pwc <= rtc_pkg::PWC_RESET; // RULE11
		end
		else if (ce)
		begin
			if (is_cal)
			begin
				if (value_write_unlock)
					module_enable <= hwdata[rtc_pkg::CAL_EN]; // RULE4
				value_write_unlock <= hwdata[rtc_pkg::CAL_UNLOCK] & (ul == rtc_pkg::UL_ARMED); // RULE23
				out_en <= hwdata[rtc_pkg::CAL_OE];
				tptr <= hwdata[9:8];
				trim <= hwdata[7:0];
			end
			if (wr && waddr == rtc_pkg::ADDR_PWC)
				pwc <= hwdata[15:8];
		end
	end

	// ----------------------------------------
	// prescaler and half second flag
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			presc <= 18'sd0;
			half_second_flag <= 1'b0;
			tick_d <= 1'b0;
			half_d <= 1'b0;
			ref_div2 <= 1'b0;
		end
		else if (ce)
		begin
			tick_d <= tick_sec;
			half_d <= tick_half;
			if (ref_edge)
				ref_div2 <= ~ref_div2;
			if (is_ms)
			begin
				presc <= 18'sd0; // RULE12
				half_second_flag <= 1'b0; // RULE5
			end
			else if (tick_sec)
			begin
				half_second_flag <= 1'b0;
				if (tm.sec == 8'h14 || tm.sec == 8'h29 || tm.sec == 8'h44 || tm.sec == 8'h59)
					presc <= 18'(signed'(trim)); // RULE1 RULE2
				else
					presc <= 18'sd0;
			end
			else if (module_enable && ref_edge)
			begin
				presc <= presc + 18'sd1;
				if (tick_half)
					half_second_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// calendar
	// ----------------------------------------
	always_comb
	begin
		c_sec = rtc_bcd_inc(tm.sec, 8'h59, 8'h00);
		c_min = rtc_bcd_inc(tm.min, 8'h59, 8'h00);
		c_hr = rtc_bcd_inc(tm.hr, 8'h23, 8'h00);
		c_day = rtc_bcd_inc(tm.day, rtc_last_day(tm.mth, tm.yr), 8'h01);
		c_mth = rtc_bcd_inc(tm.mth, 8'h12, 8'h01);
		c_yr = rtc_bcd_inc(tm.yr, 8'h99, 8'h00);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tm <= rtc_pkg::TIME_RESET;
		else if (ce)
		begin
			if (wr && value_write_unlock) // RULE22
			begin
				if (waddr == rtc_pkg::ADDR_YEAR)
					tm.yr <= hwdata[7:0];
				if (waddr == rtc_pkg::ADDR_MONTH_DAY_VALUE)
					{tm.mth, tm.day} <= {3'h0, hwdata[12:8], 2'h0, hwdata[5:0]};
				if (waddr == rtc_pkg::ADDR_WKHR)
					{tm.wd, tm.hr} <= {hwdata[10:8], 2'h0, hwdata[5:0]};
				if (waddr == rtc_pkg::ADDR_MINUTE_SECOND_VALUE)
					{tm.min, tm.sec} <= {1'b0, hwdata[14:8], 1'b0, hwdata[6:0]};
			end
			else if (tick_sec) // RULE24
			begin
				tm.sec <= c_sec[7:0];
				if (c_sec[8])
					tm.min <= c_min[7:0];
				if (c_sec[8] & c_min[8])
					tm.hr <= c_hr[7:0];
				if (c_sec[8] & c_min[8] & c_hr[8])
				begin
					tm.day <= c_day[7:0];
					tm.wd <= tm.wd == 3'h6 ? 3'h0 : tm.wd + 3'h1;
					if (c_day[8])
						tm.mth <= c_mth[7:0];
					if (c_day[8] & c_mth[8])
						tm.yr <= c_yr[7:0];
				end
			end
		end
	end

	// ----------------------------------------
	// alarm
	// ----------------------------------------
	always_comb
	begin
		unique case (alarm_interval_select) // RULE15 RULE16
			4'h0, 4'h1: match = 1'b1;
			4'h2:       match = tm.sec[3:0] == alm.sec[3:0];
			4'h3:       match = tm.sec == alm.sec;
			4'h4:       match = tm.sec == alm.sec && tm.min[3:0] == alm.min[3:0];
			4'h5:       match = {tm.min, tm.sec} == {alm.min, alm.sec};
			4'h6:       match = {tm.hr, tm.min, tm.sec} == {alm.hr, alm.min, alm.sec};
			4'h7:       match = {tm.wd, tm.hr, tm.min, tm.sec} == {alm.wd, alm.hr, alm.min, alm.sec};
			4'h8:       match = {tm.day, tm.hr, tm.min, tm.sec} == {alm.day, alm.hr, alm.min, alm.sec};
			4'h9:       match = {tm.mth, tm.day, tm.hr, tm.min, tm.sec} == {alm.mth, alm.day, alm.hr, alm.min, alm.sec};
			default:    match = 1'b0;
		endcase
		ev = alarm_enable & (tick_d & match | half_d & (alarm_interval_select == rtc_pkg::IV_HALF));
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{alarm_enable, chime, alarm_interval_select, alarm_window_pointer} <= 8'h00;
			alarm_repeat_count <= rtc_pkg::RPT_ZERO;
			alm <= '0;
		end
		else if (ce)
		begin
			if (wr && waddr == rtc_pkg::ADDR_ALCFG)
			begin
				{alarm_enable, chime, alarm_interval_select, alarm_window_pointer} <= hwdata[15:8];
				alarm_repeat_count <= hwdata[7:0];
			end
			else
			begin
				if (is_alv && alarm_window_pointer != 2'h0)
					alarm_window_pointer <= alarm_window_pointer - 2'h1; // RULE18
				if (ev && alarm_repeat_count == rtc_pkg::RPT_ZERO)
				begin
					alarm_enable <= chime; // RULE13
					alarm_repeat_count <= chime ? rtc_pkg::RPT_MAX : rtc_pkg::RPT_ZERO; // RULE14
				end
				else if (ev)
					alarm_repeat_count <= alarm_repeat_count - 8'h01; // RULE19
			end
			if (wr && waddr == rtc_pkg::ADDR_ALVAL && value_write_unlock)
			begin
				unique case (alarm_window_pointer)
					2'h0:    {alm.min, alm.sec} <= {1'b0, hwdata[14:8], 1'b0, hwdata[6:0]};
					2'h1:    {alm.wd, alm.hr} <= {hwdata[10:8], 2'h0, hwdata[5:0]};
					2'h2:    {alm.mth, alm.day} <= {3'h0, hwdata[12:8], 2'h0, hwdata[5:0]};
					default: alm.yr <= alm.yr;
				endcase
			end
		end
	end

	// ----------------------------------------
	// power control and output pin
	// ----------------------------------------
	assign win_step = ref_edge & (pw == rtc_pkg::PW_STAB ? (~pwc[5] | ref_div2) : (~pwc[4] | ref_div2)); // RULE7 RULE8

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pw <= rtc_pkg::PW_IDLE;
			win <= 8'h00;
		end
		else if (ce)
		begin
			unique case (pw)
				rtc_pkg::PW_IDLE:
				begin
					win <= 8'h00;
					if (ev && pwc[7]) // RULE6
						pw <= rtc_pkg::PW_STAB;
				end
				rtc_pkg::PW_STAB:
				begin
					if (win_step)
						win <= win + 8'h01;
					if (win_step && win == 8'(STAB_WIN - 1))
					begin
						win <= 8'h00;
						pw <= rtc_pkg::PW_SAMP;
					end
				end
				rtc_pkg::PW_SAMP:
				begin
					if (win_step)
						win <= win + 8'h01;
					if (win_step && win == 8'(SAMP_WIN - 1))
						pw <= rtc_pkg::PW_IDLE;
				end
				default: pw <= rtc_pkg::PW_IDLE;
			endcase
			if (!pwc[7])
				pw <= rtc_pkg::PW_IDLE; // RULE6
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			alarm_pulse <= 1'b0;
			power_ctl_out <= 1'b0;
			clock_out <= 1'b0;
		end
		else if (ce)
		begin
			alarm_pulse <= ev;
			power_ctl_out <= pwc[6] ? pw != rtc_pkg::PW_IDLE : pw == rtc_pkg::PW_IDLE; // RULE25
			unique case (pwc[1:0]) // RULE10
				rtc_pkg::OUT_ALARM: clock_out <= out_en & ev;
				rtc_pkg::OUT_SEC:   clock_out <= out_en & ~half_second_flag;
				rtc_pkg::OUT_REF:   clock_out <= out_en & ref_lvl;
				default:            clock_out <= out_en & (pwc[6] ? pw != rtc_pkg::PW_IDLE : pw == rtc_pkg::PW_IDLE);
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence cal_wr_s;
		ce && is_cal;
	endsequence

	en_gate_a: assert property (ce && $changed(module_enable) |-> $past(is_cal && value_write_unlock)) // RULE4
		else $error("module enable changed while locked");
	unlock_gate_a: assert property (cal_wr_s and ul != rtc_pkg::UL_ARMED |=> !value_write_unlock) // RULE23
		else $error("unlock set without key sequence");
	half_clear_a: assert property (ce && is_ms |=> !half_second_flag && presc == 18'sd0) // RULE5
		else $error("minute_second_value write did not clear half flag");
	trim_load_a: assert property (ce && tick_sec && !is_ms && !is_cal && // RULE1
		(tm.sec == 8'h14 || tm.sec == 8'h29 || tm.sec == 8'h44 || tm.sec == 8'h59) |=> presc == 18'(signed'(trim)))
		else $error("trim not applied at quarter minute");
	alarm_clear_a: assert property (ce && ev && !wr && alarm_repeat_count == 8'h00 && !chime |=> !alarm_enable) // RULE13
		else $error("alarm enable not cleared");
	chime_wrap_a: assert property (ce && ev && !wr && alarm_repeat_count == 8'h00 && chime |=> // RULE14
		alarm_repeat_count == 8'hFF)
		else $error("repeat count did not wrap");
	rpt_dec_a: assert property (ce && ev && !wr && alarm_repeat_count != 8'h00 |=>
		alarm_repeat_count == $past(alarm_repeat_count) - 8'h01) // RULE19
		else $error("repeat count did not decrement");
	ptr_dec_a: assert property (ce && is_alv && !wr && alarm_window_pointer == 2'h2 ##1 ce && !is_alv && !wr |=>
		alarm_window_pointer == 2'h1) // RULE18
		else $error("alarm pointer did not step down");
	year_zero_a: assert property (ce && acc && !hwrite && haddr[7:0] == rtc_pkg::ADDR_YEAR |=> // RULE20
		hrdata[31:8] == 24'h0)
		else $error("year upper bits not zero");
	pwr_off_a: assert property (ce && !pwc[7] |=> pw == rtc_pkg::PW_IDLE ##1 // RULE6
		power_ctl_out == !$past(pwc[6]) || !$past(ce))
		else $error("power control active while disabled");
	ready_ok_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or errored");
endmodule : rtc_calendar

// File: core/rtc_pkg.sv
// constants, field positions and carrier types of the calendar clock unit
// assumes a 32-bit ahb-lite register bus; hresetn is the power-on reset
package rtc_pkg;
	// ----------------------------------------
	// register byte addresses and unlock key values
	// ----------------------------------------
	localparam logic [7:0] ADDR_CAL    = 8'h00;
	localparam logic [7:0] ADDR_PWC    = 8'h04;
	localparam logic [7:0] ADDR_ALCFG  = 8'h08;
	localparam logic [7:0] ADDR_ALVAL  = 8'h0C;
	localparam logic [7:0] ADDR_YEAR   = 8'h10;
	localparam logic [7:0] ADDR_MONTH_DAY_VALUE  = 8'h14;
	localparam logic [7:0] ADDR_WKHR   = 8'h18;
	localparam logic [7:0] ADDR_MINUTE_SECOND_VALUE = 8'h1C;
	localparam logic [7:0] ADDR_KEY    = 8'h20;
	localparam logic [7:0] KEY_FIRST   = 8'h55;
	localparam logic [7:0] KEY_SECOND  = 8'hAA;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CAL_EN     = 15;
	localparam int CAL_UNLOCK = 13;
	localparam int CAL_OE     = 10;
	localparam int PWC_EN     = 15;
	localparam int PWC_POL    = 14;
	localparam int PWC_STAB   = 13;
	localparam int PWC_SAMP   = 12;
	localparam int ALC_EN     = 15;
	localparam int ALC_CHIME  = 14;
	// ----------------------------------------
	// codes and reset values
	// ----------------------------------------
	localparam logic [1:0] REF_SECONDARY_CRYSTAL_OSC  = 2'h0;
	localparam logic [1:0] REF_LOW_POWER_RC_OSC  = 2'h1;
	localparam logic [1:0] REF_M50   = 2'h2;
	localparam logic [1:0] OUT_ALARM = 2'h0;
	localparam logic [1:0] OUT_SEC   = 2'h1;
	localparam logic [1:0] OUT_REF   = 2'h2;
	localparam logic [3:0] IV_HALF   = 4'h0;
	localparam logic [15:0] CAL_RESET = 16'h0000;
	localparam logic [7:0] PWC_RESET  = 8'h00;
	localparam logic [7:0] RPT_MAX    = 8'hFF;
	localparam logic [7:0] RPT_ZERO   = 8'h00;
	typedef struct packed {
		logic [7:0] yr;
		logic [7:0] mth;
		logic [7:0] day;
		logic [2:0] wd;
		logic [7:0] hr;
		logic [7:0] min;
		logic [7:0] sec;
	} rtc_time_t;
	localparam rtc_time_t TIME_RESET = '{8'h00, 8'h01, 8'h01, 3'h0, 8'h00, 8'h00, 8'h00};
	typedef enum logic [2:0] {UL_IDLE = 3'b001, UL_KEY1 = 3'b010, UL_ARMED = 3'b100} rtc_unlock_t;
	typedef enum logic [2:0] {PW_IDLE = 3'b001, PW_STAB = 3'b010, PW_SAMP = 3'b100} rtc_pwr_t;
endpackage : rtc_pkg

// File: testbench/tb.sv
// self-checking bench of the calendar clock unit over its ahb-lite register bus
// assumes rtc_pkg and rtc_calendar compiled first; reference pins are made here
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk      = 1'b0;
	logic        hresetn   = 1'b0;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = 32'h0;
	logic [3:0]  sdiv      = 4'h0;
	logic        secondary_crystal_osc_pin  = 1'b0;
	logic        low_power_rc_osc_pin  = 1'b0;
	logic        mains_pin = 1'b0;
	wire         hreadyout;
	wire  [31:0] hrdata;
	wire         clock_out;
	wire         power_ctl_out;
	wire         alarm_pulse;
	int          num_errors;
	int          cmp_count;
	int          npulse;
	int          cyc;
	int          t0;
	int          i;
	logic [31:0] r;
	// ----------------------------------------
	// clock, reference pins, design
	// ----------------------------------------
	always #50 hclk = ~hclk;
	always @(posedge hclk)
	begin
		sdiv      <= sdiv + 4'h1;
		secondary_crystal_osc_pin  <= sdiv[2];
		low_power_rc_osc_pin  <= sdiv[1];
		mains_pin <= sdiv[3];
		npulse    <= npulse + int'(alarm_pulse === 1'b1);
		cyc       <= cyc + 1;
	end
	rtc_calendar #(.SECONDARY_CRYSTAL_OSC_HZ(8), .LOW_POWER_RC_OSC_HZ(6)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(), .secondary_crystal_osc_pin(secondary_crystal_osc_pin), .low_power_rc_osc_pin(low_power_rc_osc_pin), .mains_pin(mains_pin),
		.clock_out(clock_out), .power_ctl_out(power_ctl_out), .alarm_pulse(alarm_pulse));
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		check(nm, r, exp);
	endtask : rdc
	task automatic unlock();
		bus(1'b1, rtc_pkg::ADDR_KEY, 32'h55);
		bus(1'b1, rtc_pkg::ADDR_KEY, 32'hAA);
	endtask : unlock
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdc(rtc_pkg::ADDR_CAL, 32'h0, "cal");
		rdc(rtc_pkg::ADDR_PWC, 32'h0, "pwc");
		rdc(rtc_pkg::ADDR_ALCFG, 32'h0, "alcfg");
		rdc(rtc_pkg::ADDR_YEAR, 32'h0, "year");
		rdc(rtc_pkg::ADDR_MONTH_DAY_VALUE, 32'h0101, "month_day_value");
		rdc(8'h24, 32'h0, "unmapped");
		$display("reset values done");
	endtask : t_reset
	task automatic t_lock();
		bus(1'b1, rtc_pkg::ADDR_YEAR, 32'h47);
		rdc(rtc_pkg::ADDR_YEAR, 32'h0, "locked year");
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'h8000);
		rdc(rtc_pkg::ADDR_CAL, 32'h0, "locked enable");
		unlock();
		bus(1'b1, 8'h24, 32'h0);
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'h2000);
		rdc(rtc_pkg::ADDR_CAL, 32'h0, "late unlock");
		unlock();
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'h2000);
		rdc(rtc_pkg::ADDR_CAL, 32'h2000, "unlock");
		bus(1'b1, rtc_pkg::ADDR_YEAR, 32'h1247);
		rdc(rtc_pkg::ADDR_YEAR, 32'h47, "year");
		bus(1'b1, rtc_pkg::ADDR_MONTH_DAY_VALUE, 32'hE1D2);
		rdc(rtc_pkg::ADDR_MONTH_DAY_VALUE, 32'h0112, "month_day_value");
		bus(1'b1, rtc_pkg::ADDR_WKHR, 32'hFD23);
		rdc(rtc_pkg::ADDR_WKHR, 32'h0523, "wkhr");
		$display("write lock done");
	endtask : t_lock
	task automatic t_ptr();
		bus(1'b1, rtc_pkg::ADDR_ALCFG, 32'h0200);
		bus(1'b0, rtc_pkg::ADDR_ALVAL, 32'h0);
		rdc(rtc_pkg::ADDR_ALCFG, 32'h0100, "ptr read");
		bus(1'b1, rtc_pkg::ADDR_ALVAL, 32'h0);
		rdc(rtc_pkg::ADDR_ALCFG, 32'h0, "ptr write");
		bus(1'b1, rtc_pkg::ADDR_ALVAL, 32'h0512);
		rdc(rtc_pkg::ADDR_ALVAL, 32'h0512, "window");
		rdc(rtc_pkg::ADDR_ALCFG, 32'h0, "ptr floor");
		$display("alarm pointer done");
	endtask : t_ptr
	task automatic t_alarm();
		unlock();
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'hA000);
		bus(1'b1, rtc_pkg::ADDR_MINUTE_SECOND_VALUE, 32'h0);
		bus(1'b1, rtc_pkg::ADDR_ALCFG, 32'h8002);
		i = npulse;
		repeat (160) @(posedge hclk);
		check("alarm count", npulse - i, 3);
		rdc(rtc_pkg::ADDR_ALCFG, 32'h0, "alarm off");
		bus(1'b1, rtc_pkg::ADDR_ALCFG, 32'hC000);
		i = 0;
		while (alarm_pulse !== 1'b1 && i < 100)
		begin
			@(posedge hclk);
			i++;
		end
		rdc(rtc_pkg::ADDR_ALCFG, 32'hC0FF, "chime");
		bus(1'b1, rtc_pkg::ADDR_ALCFG, 32'h0);
		$display("alarm done");
	endtask : t_alarm
	task automatic t_half();
		i = 0;
		r = 32'h0;
		while (r[11] !== 1'b1 && i < 60)
		begin
			bus(1'b0, rtc_pkg::ADDR_CAL, 32'h0);
			i++;
		end
		check("half set", r, 32'hA800);
		bus(1'b1, rtc_pkg::ADDR_MINUTE_SECOND_VALUE, 32'h0);
		rdc(rtc_pkg::ADDR_CAL, 32'hA000, "half clear");
		$display("half second done");
	endtask : t_half
	task automatic t_pwc();
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'h4000);
		repeat (4) @(posedge hclk);
		check("pol idle", power_ctl_out, 1'b0);
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'hC000);
		bus(1'b1, rtc_pkg::ADDR_ALCFG, 32'h8000);
		i = 0;
		while (power_ctl_out !== 1'b1 && i < 200)
		begin
			@(posedge hclk);
			i++;
		end
		check("pwc active", power_ctl_out, 1'b1);
		repeat (300) @(posedge hclk);
		check("pwc done", power_ctl_out, 1'b0);
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'h0);
		repeat (4) @(posedge hclk);
		check("pol low", power_ctl_out, 1'b1);
		$display("power control done");
	endtask : t_pwc
	task automatic t_out();
		check("oe off", clock_out, 1'b0);
		unlock();
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'hA400);
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'h0300);
		repeat (4) @(posedge hclk);
		check("out pwc", clock_out, 1'b1);
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'h4300);
		repeat (4) @(posedge hclk);
		check("out pwc pol", clock_out, 1'b0);
		$display("output select done");
	endtask : t_out
	task automatic t_trim();
		bus(1'b1, rtc_pkg::ADDR_PWC, 32'h0400);
		unlock();
		bus(1'b1, rtc_pkg::ADDR_CAL, 32'hA0FE);
		bus(1'b1, rtc_pkg::ADDR_MINUTE_SECOND_VALUE, 32'h0014);
		r = 32'h0;
		i = 0;
		while (r[7:0] !== 8'h15 && i < 100)
		begin
			bus(1'b0, rtc_pkg::ADDR_MINUTE_SECOND_VALUE, 32'h0);
			i++;
		end
		t0 = cyc;
		while (r[7:0] !== 8'h16 && i < 200)
		begin
			bus(1'b0, rtc_pkg::ADDR_MINUTE_SECOND_VALUE, 32'h0);
			i++;
		end
		check("trim second", 32'(cyc - t0 > 28 && cyc - t0 < 36), 32'h1);
		$display("drift trim done");
	endtask : t_trim
	// ----------------------------------------
	// sequence, watchdog, verdict
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_lock();
		t_ptr();
		t_alarm();
		t_half();
		t_pwc();
		t_out();
		t_trim();
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		close_out();
	end
endmodule : tb
